// ==== src/eaor_regs.vh ====
/*
 * Register map, field positions, reset values and gain constants of the
 * embedded audio output router.
 * Assumes byte addressing on an Avalon-MM slave with 32-bit data.
 */
`ifndef EAOR_REGS_VH
`define EAOR_REGS_VH

// --------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------
`define EAOR_CTRL_OFS 8'h00
`define EAOR_STAT_OFS 8'h04
`define EAOR_CFG_BASE 8'h40
`define EAOR_MTR_BASE 8'h80
`define EAOR_REGION_MASK 8'hc0

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define EAOR_FEED_RST 3'h0
`define EAOR_GRP_RST 4'hf
`define EAOR_SRC_SILENCE 5'h10
`define EAOR_GAIN_RST 8'h00
`define EAOR_GAIN_MIN 8'hb0
`define EAOR_GAIN_MAX 8'h14

// --------------------------------------------------------------
// gain arithmetic
// --------------------------------------------------------------
`define EAOR_GAIN_BIAS 8'h54
`define EAOR_DB_STEP 7'h06
`define EAOR_Q_SHIFT 6'h1d
`define EAOR_TAB0 17'h08000
`define EAOR_TAB1 17'h08f9e
`define EAOR_TAB2 17'h0a124
`define EAOR_TAB3 17'h0b4ce
`define EAOR_TAB4 17'h0cade
`define EAOR_TAB5 17'h0e39f
`define EAOR_SMAX 24'h7fffff
`define EAOR_SMIN 24'h800000

`endif

// ==== src/eaor_fifo.v ====
/*
 * Synchronous FIFO for processed output samples.
 * Assumes one clock and an asynchronous active-high reset; DEPTH is 2**AW.
 */
`timescale 1ns/1ns
module eaor_fifo #(
    parameter W = 29,
    parameter AW = 4,
    parameter DEPTH = 16
) (
    input wire ref_clk,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0] count
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire push;
    wire pop;

    assign count = wr_ptr - rd_ptr;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ==== src/eaor_router.v ====
/*
 * Embedded audio output router: takes the sample stream of all input feeds,
 * keeps one frame of the selected feed, routes, scales, mutes and inverts
 * each of sixteen output channels, meters them and queues them for the
 * output embedders through a FIFO.
 * Assumes the feed stream and the embedders run on ref_clk; registers are
 * reached over Avalon-MM with waitrequest.
 */
`timescale 1ns/1ns
`include "eaor_regs.vh"

// What this block does
// - one input feed, chosen in the control register, supplies the four-group audio used for the output.
// - output channels one to eight are flagged as also carried in the hdmi embedded audio.
// - every output channel picks its own source among the sixteen embedded channels of that feed.
// - a silence source is offered, and software should give it to every unused output channel.
// - each of the four audio groups can be enabled or disabled, and a disabled group is not output.
// - every output channel has a gain from -80 dB to +20 dB in 1 dB steps, 0 dB being unity.
// - every output channel has its own mute forcing silence and its own invert negating the sample.
// - every output channel has a peak meter that sees the sample after gain, mute and invert.
// - at 0 dB non-pcm payloads pass unchanged, and software keeps 0 dB on channels carrying them.
module eaor_router #(
    parameter SW = 24,
    parameter FIFO_AW = 4,
    parameter FIFO_DEPTH = 16
) (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire in_valid,
    output wire in_ready,
    input wire [2:0] in_feed,
    input wire [3:0] in_chan,
    input wire [SW-1:0] in_data,
    input wire in_last,
    output wire out_valid,
    input wire out_ready,
    output wire [3:0] out_chan,
    output wire [SW-1:0] out_data,
    output wire out_hdmi
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    localparam FW = SW + 5;

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    reg ack;
    reg [2:0] feed_sel;
    reg [3:0] grp_en;
    reg state;
    reg [3:0] cur_ch;
    reg [15:0] frame_cnt;
    wire req;
    wire wr_go;
    wire rd_go;
    wire [7:0] region;
    wire [3:0] idx;
    wire is_cfg;
    wire is_mtr;
    wire [FIFO_AW:0] fifo_count;
    wire fifo_in_ready;

    // every access takes two cycles: waitrequest high on the first, low on the second
    assign req = read | write;
    assign waitrequest = req & ~ack;
    assign wr_go = write & ack;
    assign rd_go = read & ack;
    assign region = address & `EAOR_REGION_MASK;
    assign idx = address[5:2];
    assign is_cfg = (region == `EAOR_CFG_BASE);
    assign is_mtr = (region == `EAOR_MTR_BASE);

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            feed_sel <= `EAOR_FEED_RST;
            grp_en <= `EAOR_GRP_RST;
        end else if (wr_go && address == `EAOR_CTRL_OFS && byteenable[0]) begin
            feed_sel <= writedata[2:0];
            grp_en <= writedata[7:4];
        end
    end

    // --------------------------------------------------------------
    // per-channel storage: frame buffer, settings, peak meters
    // --------------------------------------------------------------
    wire [SW-1:0] smp_w [0:15];
    wire [4:0] src_w [0:15];
    wire [7:0] gain_w [0:15];
    wire [15:0] mute_w;
    wire [15:0] inv_w;
    wire [SW-1:0] peak_w [0:15];
    wire step;
    wire [SW-1:0] mag;
    wire signed [7:0] wr_gain;
    wire [7:0] wr_gain_cl;

    // the stored gain is clamped, so a readback shows the gain really in use
    assign wr_gain = writedata[23:16];
    assign wr_gain_cl = (wr_gain < $signed(`EAOR_GAIN_MIN)) ? `EAOR_GAIN_MIN :
        ((wr_gain > $signed(`EAOR_GAIN_MAX)) ? `EAOR_GAIN_MAX : wr_gain);

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ch
            localparam [31:0] CH = gi;
            reg [SW-1:0] smp;
            reg [4:0] src;
            reg [7:0] gain;
            reg mute;
            reg inv;
            reg [SW-1:0] peak;
            wire cfg_wr;
            wire hit;
            wire clr;

            assign cfg_wr = wr_go & is_cfg & (idx == gi);
            assign hit = step & (cur_ch == gi);
            assign clr = rd_go & is_mtr & (idx == gi);

            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    smp <= {SW{1'b0}};
                end else if (in_valid && in_ready && in_feed == feed_sel && in_chan == gi) begin
                    smp <= in_data;
                end
            end

            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    src <= CH[4:0];
                    gain <= `EAOR_GAIN_RST;
                    mute <= 1'b0;
                    inv <= 1'b0;
                end else if (cfg_wr) begin
                    if (byteenable[0]) begin
                        src <= writedata[4:0];
                    end
                    if (byteenable[1]) begin
                        mute <= writedata[8];
                        inv <= writedata[9];
                    end
                    if (byteenable[2]) begin
                        gain <= wr_gain_cl;
                    end
                end
            end

            // a new peak arriving in the cycle of the read-clear is kept
            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    peak <= {SW{1'b0}};
                end else if (hit && (clr || mag > peak)) begin
                    peak <= mag;
                end else if (clr) begin
                    peak <= {SW{1'b0}};
                end
            end

            assign smp_w[gi] = smp;
            assign src_w[gi] = src;
            assign gain_w[gi] = gain;
            assign mute_w[gi] = mute;
            assign inv_w[gi] = inv;
            assign peak_w[gi] = peak;
        end
    endgenerate

    // --------------------------------------------------------------
    // read data
    // --------------------------------------------------------------
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            readdata <= 32'h00000000;
        end else if (read && !ack) begin
            if (address == `EAOR_CTRL_OFS) begin
                readdata <= {24'h000000, grp_en, 1'b0, feed_sel};
            end else if (address == `EAOR_STAT_OFS) begin
                readdata <= {frame_cnt, 9'h000, fifo_count, ~fifo_in_ready, state};
            end else if (is_cfg) begin
                readdata <= {8'h00, gain_w[idx], 6'h00, inv_w[idx], mute_w[idx], 3'h0, src_w[idx]};
            end else if (is_mtr) begin
                readdata <= {{(32-SW){1'b0}}, peak_w[idx]};
            end else begin
                readdata <= 32'h00000000;
            end
        end
    end

    // --------------------------------------------------------------
    // frame sequencer
    // --------------------------------------------------------------
    wire grp_on;
    wire last_ch;
    reg next_state;

    // the buffer is frozen while channels are processed, so the source stalls
    assign in_ready = (state == ST_IDLE);
    assign grp_on = grp_en[cur_ch[3:2]];
    // a disabled group never waits on the fifo, its samples are simply dropped
    assign step = (state == ST_RUN) & (fifo_in_ready | ~grp_on);
    assign last_ch = (cur_ch == 4'hf);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (in_valid && in_last) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (step && last_ch) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            cur_ch <= 4'h0;
            frame_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            if (step) begin
                cur_ch <= cur_ch + 4'h1;
            end
            if (step && last_ch) begin
                frame_cnt <= frame_cnt + 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------
    // channel processing
    // --------------------------------------------------------------
    wire [4:0] cur_src;
    wire signed [SW-1:0] raw;
    wire signed [7:0] g_in;
    reg signed [7:0] g_cl;
    wire [7:0] e;
    wire [6:0] k;
    wire [6:0] r;
    reg [16:0] tab;
    wire signed [SW+17:0] prod;
    wire signed [SW+17:0] shifted;
    wire [5:0] shamt;
    wire signed [SW+17:0] lim_hi;
    wire signed [SW+17:0] lim_lo;
    reg signed [SW-1:0] gained;
    reg signed [SW-1:0] polar;
    wire signed [SW-1:0] final_s;

    assign cur_src = src_w[cur_ch];
    // any source code from sixteen upward is silence
    assign raw = (cur_src >= `EAOR_SRC_SILENCE) ? {SW{1'b0}} : smp_w[cur_src[3:0]];
    assign g_in = gain_w[cur_ch];

    always @* begin
        if (g_in < $signed(`EAOR_GAIN_MIN)) begin
            g_cl = `EAOR_GAIN_MIN;
        end else if (g_in > $signed(`EAOR_GAIN_MAX)) begin
            g_cl = `EAOR_GAIN_MAX;
        end else begin
            g_cl = g_in;
        end
    end

    // 6 dB per binary shift plus a fine table; about 0.02 dB error per 6 dB of distance
    assign e = g_cl + `EAOR_GAIN_BIAS;
    assign k = e[6:0] / `EAOR_DB_STEP;
    assign r = e[6:0] % `EAOR_DB_STEP;

    always @* begin
        case (r[2:0])
            3'h0: tab = `EAOR_TAB0;
            3'h1: tab = `EAOR_TAB1;
            3'h2: tab = `EAOR_TAB2;
            3'h3: tab = `EAOR_TAB3;
            3'h4: tab = `EAOR_TAB4;
            3'h5: tab = `EAOR_TAB5;
            default: tab = `EAOR_TAB0;
        endcase
    end

    assign prod = raw * $signed({1'b0, tab});
    assign shamt = `EAOR_Q_SHIFT - k[5:0];
    assign shifted = prod >>> shamt;
    assign lim_hi = {{18{1'b0}}, `EAOR_SMAX};
    assign lim_lo = {{18{1'b1}}, `EAOR_SMIN};

    always @* begin
        if (g_cl == `EAOR_GAIN_RST) begin
            gained = raw;
        end else if (shifted > lim_hi) begin
            gained = `EAOR_SMAX;
        end else if (shifted < lim_lo) begin
            gained = `EAOR_SMIN;
        end else begin
            gained = shifted[SW-1:0];
        end
    end

    // negating full scale negative would wrap, so it saturates instead
    always @* begin
        if (!inv_w[cur_ch]) begin
            polar = gained;
        end else if (gained == $signed(`EAOR_SMIN)) begin
            polar = `EAOR_SMAX;
        end else begin
            polar = -gained;
        end
    end

    assign final_s = mute_w[cur_ch] ? {SW{1'b0}} : polar;
    assign mag = final_s[SW-1] ? ((final_s == $signed(`EAOR_SMIN)) ? `EAOR_SMAX : -final_s) : final_s;

    // --------------------------------------------------------------
    // output queue
    // --------------------------------------------------------------
    wire [FW-1:0] fifo_out;

    eaor_fifo #(
        .W(FW),
        .AW(FIFO_AW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(step & grp_on),
        .in_ready(fifo_in_ready),
        .in_data({~cur_ch[3], cur_ch, final_s}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out),
        .count(fifo_count)
    );

    assign out_hdmi = fifo_out[FW-1];
    assign out_chan = fifo_out[FW-2:SW];
    assign out_data = fifo_out[SW-1:0];
endmodule

// ==== test/eaor_properties.sv ====
/*
 * Port checker for eaor_router, bound to every instance.
 * Assumes software changes group enables only while no words are queued.
 */
`timescale 1ns/1ns
module eaor_props #(
    parameter SW = 24
) (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire in_valid,
    input wire in_ready,
    input wire in_last,
    input wire out_valid,
    input wire out_ready,
    input wire [3:0] out_chan,
    input wire [SW-1:0] out_data,
    input wire out_hdmi
);
// ----------------------------------------
// shadow of the group enables
// ----------------------------------------
reg [3:0] grp;
wire rdone = read && !waitrequest;
always @(posedge ref_clk or posedge reset) begin
    if (reset)
        grp <= 4'hf;
    else if (write && !waitrequest && address == 8'h00 && byteenable[0])
        grp <= writedata[7:4];
end
default clocking cb @(posedge ref_clk); endclocking
default disable iff (reset);
a_wait_first: assert property ($rose(read || write) |-> waitrequest) else $error("no wait cycle");
a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
a_ctrl_read: assert property (rdone && address == 8'h00 |-> readdata[7:4] == grp) else $error("groups");
a_hdmi_flag: assert property (out_valid |-> out_hdmi == (out_chan < 4'h8)) else $error("hdmi flag");
a_head_stand: assert property (out_valid && !out_ready |=> out_valid && $stable(out_chan) && $stable(out_data))
    else $error("head word moved");
a_group_drop: assert property (out_valid |-> grp[out_chan[3:2]]) else $error("disabled group out");
a_gain_clamp: assert property (rdone && address[7:6] == 2'b01 |-> $signed(readdata[23:16]) >= -80 &&
    $signed(readdata[23:16]) <= 20) else $error("gain range");
a_frame_busy: assert property (in_valid && in_ready && in_last |=> !in_ready [*8]) else $error("ready early");
a_frame_out: assert property (in_valid && in_ready && in_last && grp != 4'h0 |-> ##[1:40] out_valid)
    else $error("no output");
a_meter_top: assert property (rdone && address[7:6] == 2'b10 |-> readdata[31:24] == 8'h00) else $error("meter");
endmodule
bind eaor_router eaor_props #(.SW(SW)) u_props (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .in_valid(in_valid), .in_ready(in_ready), .in_last(in_last),
    .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan), .out_data(out_data), .out_hdmi(out_hdmi));

// ==== test/eaor_sink.sv ====
/*
 * Output embedder stand-in: takes words promptly, at random, or not at all.
 * Assumes out_valid comes from the router's FIFO on the same clock.
 */
`timescale 1ns/1ns
module eaor_sink (
    input wire ref_clk,
    input wire reset,
    input wire hold,
    input wire slow,
    input wire out_valid,
    output reg out_ready,
    output wire pop
);
// ----------------------------------------
// ready pattern
// ----------------------------------------
reg [7:0] lfsr;
assign pop = out_valid && out_ready;
always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
        lfsr <= 8'h5a;
        out_ready <= 1'b0;
    end else begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        out_ready <= !hold && (!slow || lfsr[0]);
    end
end
endmodule

// ==== test/tb_top.sv ====
/*
 * Self-checking bench for eaor_router: register bus, input frames, output words.
 * Assumes the sink model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module tb_top;
reg ref_clk = 1'b0;
reg reset = 1'b1;
reg [7:0] address = 8'h00;
reg read = 1'b0;
reg write = 1'b0;
reg [31:0] writedata = 32'h0;
reg in_valid = 1'b0;
reg [2:0] in_feed = 3'h0;
reg [3:0] in_chan = 4'h0;
reg [23:0] in_data = 24'h0;
reg in_last = 1'b0;
reg hold = 1'b0;
reg slow = 1'b0;
wire [31:0] readdata;
wire waitrequest, in_ready, out_valid, out_ready, out_hdmi, pop;
wire [3:0] out_chan;
wire [23:0] out_data;
integer bad_count = 0;
integer checks = 0;
integer i, n;
reg [31:0] seed = 32'h2528;
reg [31:0] q;
reg [23:0] e;
reg [23:0] src [0:15];
reg [28:0] expq [$];
eaor_router dut_u (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .in_valid(in_valid), .in_ready(in_ready), .in_feed(in_feed), .in_chan(in_chan), .in_data(in_data),
    .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan),
    .out_data(out_data), .out_hdmi(out_hdmi));
eaor_sink sink_u (.ref_clk(ref_clk), .reset(reset), .hold(hold), .slow(slow), .out_valid(out_valid),
    .out_ready(out_ready), .pop(pop));
always #5 ref_clk = ~ref_clk;
// ----------------------------------------
// helpers
// ----------------------------------------
function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
function [23:0] mag(input [23:0] x);
    mag = x[23] ? -x : x;
endfunction
task conclude;
    begin
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
endtask
task fail(input [31:0] got, input [31:0] exp);
    begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
endtask
task cmp_reg(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) fail(got, exp);
    end
endtask
task cmp_word(input [28:0] got, input [28:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) fail({3'h0, got}, {3'h0, exp});
    end
endtask
// request held until waitrequest is seen low, then released
task bus(input w, input [7:0] a, input [31:0] d);
    begin
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        @(posedge ref_clk);
        while (waitrequest) @(posedge ref_clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    end
endtask
task rd(input [7:0] a, input [31:0] x);
    begin
        bus(1'b0, a, 32'h0);
        cmp_reg(q, x);
    end
endtask
task drain;
    begin
        repeat (400) if (expq.size() != 0) @(posedge ref_clk);
        cmp_reg(expq.size(), 32'h0);
    end
endtask
// mod selects the reversed routing with silence, mute, invert and +-6 dB channels
task frame(input mod, input [3:0] g);
    begin
        for (n = 0; n < 16; n = n + 1) begin
            seed = xs(seed);
            src[n] = {{2{seed[21]}}, seed[21:1], 1'b0};
        end
        for (n = 0; n < 16; n = n + 1) begin
            e = mod ? (n == 3 ? 24'h0 : src[15 - n]) : src[n];
            if (mod && n == 6) e = e << 1;
            if (mod && n == 7) e = {e[23], e[23:1]};
            if (mod && n == 5) e = -e;
            if (mod && n == 4) e = 24'h0;
            if (g[n / 4]) expq.push_back({n < 8, n[3:0], e});
        end
        for (n = 0; n < 17; n = n + 1) begin
            in_valid <= 1'b1;
            in_feed <= n == 16 ? 3'h5 : 3'h2;
            in_chan <= n == 16 ? 4'h3 : n[3:0];
            in_data <= n == 16 ? seed[23:0] : src[n[3:0]];
            in_last <= n == 16;
            @(posedge ref_clk);
            while (!in_ready) @(posedge ref_clk);
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
    end
endtask
always @(posedge ref_clk) begin
    if (pop) begin
        if (expq.size() == 0) fail({3'h0, out_hdmi, out_chan, out_data}, 32'h0);
        else cmp_word({out_hdmi, out_chan, out_data}, expq.pop_front());
    end
end
initial begin
    #100000;
    bad_count = bad_count + 1;
    conclude;
end
// ----------------------------------------
// scenarios
// ----------------------------------------
initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00, 32'h000000f0);
    rd(8'h54, 32'h00000005);
    rd(8'h3c, 32'h0);
    bus(1'b1, 8'h00, 32'h000000f2);
    rd(8'h00, 32'h000000f2);
    frame(1'b0, 4'hf);
    drain;
    rd(8'h80, {8'h0, mag(src[0])});
    for (i = 4; i < 7; i = i + 1) bus(1'b0, 8'h80 + 4 * i, 32'h0);
    for (i = 0; i < 16; i = i + 1)
        bus(1'b1, 8'h40 + 4 * i, {8'h0, i == 6 ? 8'h06 : i == 7 ? 8'hfa : 8'h00, 6'h0, i == 5, i == 4, 3'h0,
            i == 3 ? 5'h10 : 5'd15 - i[4:0]});
    rd(8'h54, 32'h0000020a);
    frame(1'b1, 4'hf);
    drain;
    rd(8'h90, 32'h0);
    rd(8'h94, {8'h0, mag(src[10])});
    rd(8'h94, 32'h0);
    rd(8'h98, {8'h0, mag(src[9] << 1)});
    bus(1'b1, 8'h60, 32'h001e0007);
    rd(8'h60, 32'h00140007);
    bus(1'b1, 8'h60, 32'h009c0007);
    rd(8'h60, 32'h00b00007);
    bus(1'b1, 8'h60, 32'h00000007);
    hold <= 1'b1;
    frame(1'b1, 4'hf);
    q = 32'h0;
    for (i = 0; i < 50 && !q[1]; i = i + 1) bus(1'b0, 8'h04, 32'h0);
    cmp_reg(q, 32'h00030042);
    hold <= 1'b0;
    slow <= 1'b1;
    drain;
    bus(1'b1, 8'h00, 32'h000000a2);
    frame(1'b1, 4'ha);
    drain;
    bus(1'b1, 8'h00, 32'h00000002);
    frame(1'b1, 4'h0);
    repeat (40) @(posedge ref_clk);
    conclude;
end
endmodule
